// ==== hdl/ctl_pkg.sv ====
package ctl_pkg;
  // register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h13C;
  localparam logic [ADDR_W-1:0] NIEN_OFS = 12'h180;
  localparam logic [ADDR_W-1:0] FIEN_OFS = 12'h184;
  // control register fields
  localparam int INIT_BIT = 0;
  localparam int SERR_REQ_BIT = 1;
  localparam int ZERO_BIT = 2;
  localparam int FLAG_LO = 3;
  localparam int FLAG_N = 4;
  // positions inside the flag vector
  localparam int F_RSERR = 0;
  localparam int F_CPU_PERR = 1;
  localparam int F_PCI_PERR = 2;
  localparam int F_DMA_PERR = 3;
  // reset values
  localparam logic CTRL_INIT_RST = 1'b0;
  localparam logic CTRL_SERR_RST = 1'b0;
  localparam logic [FLAG_N-1:0] FLAG_RST = 4'h0;
  localparam logic [FLAG_N-1:0] EN_RST = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
  // serr pulse sequencing
  typedef enum logic [1:0] {serr_idle, serr_drive, serr_hold} serr_state_t;
endpackage

// ==== hdl/flag_if.sv ====
`timescale 1ns/1ps
interface flag_if #(parameter int N = 4);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] q;
  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface

// ==== hdl/w1c_flags.sv ====
`timescale 1ns/1ps
module w1c_flags #(
  parameter int N = 4,
  parameter logic [N-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // flag vector
  flag_if.owner f
);
  typedef struct packed {
    logic [N-1:0] q;
  } flag_state_t;

  flag_state_t st_reg;
  flag_state_t st_next;

  // a set in the same cycle as a clear keeps the flag up
  always_comb
  begin
    st_next = st_reg;
    st_next.q = (st_reg.q & ~f.clr) | f.set;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '{q: RST};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign f.q = st_reg.q;
endmodule

// ==== hdl/proc_ctrl_status.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module proc_ctrl_status (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [ctl_pkg::ADDR_W-1:0] addr,
  input wire logic [ctl_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ctl_pkg::DATA_W-1:0] rdata,
  // pci target decode
  input wire logic cfg_hit,
  input wire logic iomem_hit,
  output logic cfg_retry,
  output logic cfg_normal,
  output logic devsel_claim,
  // system error pin
  input wire logic central_fn,
  input wire logic cmd_serr_en,
  input wire logic serr_in_n,
  output logic serr_out_n,
  output logic serr_oe,
  // sdram parity reports
  input wire logic parity_en,
  input wire logic cpu_perr,
  input wire logic pci_perr,
  input wire logic dma_perr,
  // interrupts to the local processor
  output logic normal_irq,
  output logic fast_irq
);
  import ctl_pkg::*;

  typedef struct packed {
    logic init_done;
    logic serr_req;
    serr_state_t serr_st;
    logic [FLAG_N-1:0] normal_interrupt_enable_reg;
    logic [FLAG_N-1:0] fast_interrupt_enable_reg;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  flag_if #(.N(FLAG_N)) fl ();

  logic wr_ctrl;
  logic rd_ctrl;
  logic serr_cond;
  logic rserr_evt;
  logic [FLAG_N-1:0] set_vec;

  assign wr_ctrl = wr_en && (addr == CTRL_OFS);
  assign rd_ctrl = rd_en && (addr == CTRL_OFS);

  // only the central function samples foreign SERR#, and our own drive is not foreign
  assign rserr_evt = !serr_in_n && central_fn && !serr_oe;
  assign serr_cond = st_reg.serr_req && !central_fn && cmd_serr_en;

  always_comb
  begin
    set_vec = '0;
    set_vec[F_RSERR] = rserr_evt;
    set_vec[F_CPU_PERR] = cpu_perr && parity_en;
    set_vec[F_PCI_PERR] = pci_perr && parity_en;
    set_vec[F_DMA_PERR] = dma_perr && parity_en;
  end

  assign fl.set = set_vec;
  // zero bits of a write leave the flags alone
  assign fl.clr = wr_ctrl ? wdata[FLAG_LO +: FLAG_N] : '0;

  w1c_flags #(.N(FLAG_N), .RST(FLAG_RST)) flags_u (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .f(fl)
  );

  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = '0;
    if (wr_en)
    begin
      if (addr == CTRL_OFS)
      begin
        st_next.init_done = wdata[INIT_BIT];
        st_next.serr_req = wdata[SERR_REQ_BIT];
      end
      else if (addr == NIEN_OFS)
      begin
        st_next.normal_interrupt_enable_reg = wdata[FLAG_LO +: FLAG_N];
      end
      else if (addr == FIEN_OFS)
      begin
        st_next.fast_interrupt_enable_reg = wdata[FLAG_LO +: FLAG_N];
      end
    end
    // unmapped reads return zero; bit 2 always reads zero
    if (rd_en)
    begin
      if (addr == CTRL_OFS)
      begin
        st_next.rdata[INIT_BIT] = st_reg.init_done;
        st_next.rdata[SERR_REQ_BIT] = st_reg.serr_req;
        st_next.rdata[ZERO_BIT] = 1'b0;
        st_next.rdata[FLAG_LO +: FLAG_N] = fl.q;
      end
      else if (addr == NIEN_OFS)
      begin
        st_next.rdata[FLAG_LO +: FLAG_N] = st_reg.normal_interrupt_enable_reg;
      end
      else if (addr == FIEN_OFS)
      begin
        st_next.rdata[FLAG_LO +: FLAG_N] = st_reg.fast_interrupt_enable_reg;
      end
    end
    // a held request gives one pulse, then waits for the condition to drop
    // so a request bit left set does not stream SERR# every other cycle
    unique case (st_reg.serr_st)
      serr_idle:
      begin
        if (serr_cond)
        begin
          st_next.serr_st = serr_drive;
        end
      end
      serr_drive:
      begin
        st_next.serr_st = serr_cond ? serr_hold : serr_idle;
      end
      serr_hold:
      begin
        if (!serr_cond)
        begin
          st_next.serr_st = serr_idle;
        end
      end
      default:
      begin
        st_next.serr_st = serr_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg.init_done <= CTRL_INIT_RST;
      st_reg.serr_req <= CTRL_SERR_RST;
      st_reg.serr_st <= serr_idle;
      st_reg.normal_interrupt_enable_reg <= EN_RST;
      st_reg.fast_interrupt_enable_reg <= EN_RST;
      st_reg.rdata <= RDATA_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;

  // target responses gated by init-done
  assign cfg_retry = cfg_hit && !st_reg.init_done;
  assign cfg_normal = cfg_hit && st_reg.init_done;
  assign devsel_claim = iomem_hit && st_reg.init_done;

  // open-drain: only ever pulls low
  assign serr_oe = (st_reg.serr_st == serr_drive);
  assign serr_out_n = !serr_oe;

  assign normal_irq = |(fl.q & st_reg.normal_interrupt_enable_reg);
  assign fast_irq = |(fl.q & st_reg.fast_interrupt_enable_reg);

  // checks

  sequence serr_one_pulse;
    serr_oe ##1 !serr_oe;
  endsequence

  sequence serr_armed;
    (st_reg.serr_st == serr_idle) && serr_cond;
  endsequence

  retry_uninit_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (cfg_hit && !st_reg.init_done) |-> (cfg_retry && !cfg_normal))
  else $error("config cycle not retried before init done");

  no_claim_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !st_reg.init_done |-> !devsel_claim)
  else $error("devsel claimed before init done");

  init_write_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (wr_ctrl && wdata[0] && cfg_hit) ##1 cfg_hit |-> cfg_normal && !cfg_retry)
  else $error("config cycle not normal after init done set");

  serr_pulse_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    serr_armed |=> serr_one_pulse)
  else $error("serr pulse not exactly one cycle");

  serr_cause_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $rose(serr_oe) |-> $past(serr_cond) && !serr_out_n)
  else $error("serr driven without request");

  rserr_set_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (!serr_in_n && central_fn && !serr_oe) |=> fl.q[0])
  else $error("received serr flag not set");

  cpu_perr_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (cpu_perr && parity_en) |=> fl.q[1] ##1 (fl.q[1] || $past(wr_ctrl && wdata[4])))
  else $error("processor parity flag not set or lost");

  pci_perr_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (pci_perr && parity_en) |=> fl.q[2])
  else $error("pci parity flag not set");

  dma_perr_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (dma_perr && parity_en) |=> fl.q[3])
  else $error("dma parity flag not set");

  flag_sticky_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !wr_ctrl |=> ((fl.q & $past(fl.q)) == $past(fl.q)))
  else $error("flag dropped without a clear");

  flag_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (wr_ctrl && wdata[3] && !(!serr_in_n && central_fn && !serr_oe)) |=> !fl.q[0])
  else $error("received serr flag not cleared by one");

  irq_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (st_reg.normal_interrupt_enable_reg == 4'h0) |-> !normal_irq)
  else $error("normal interrupt without enable");

  irq_raise_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    ((cpu_perr && parity_en) && st_reg.fast_interrupt_enable_reg[1]
      && !(wr_en && addr == FIEN_OFS)) |=> fast_irq)
  else $error("fast interrupt not raised by enabled flag");

  bit2_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    rd_ctrl |=> (rdata[2] == 1'b0) && (rdata[0] == $past(st_reg.init_done)))
  else $error("control read returns wrong low bits");

  read_once_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !rd_en |=> (rdata == 32'h0000_0000))
  else $error("read data present without a read");

  perr_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !parity_en |=> ((fl.q[3:1] & ~$past(fl.q[3:1])) == 3'h0))
  else $error("parity flag raised with checking off");

  cpu_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (wr_ctrl && wdata[4] && !(cpu_perr && parity_en)) |=> !fl.q[1])
  else $error("processor parity flag not cleared by one");

  pci_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (wr_ctrl && wdata[5] && !(pci_perr && parity_en)) |=> !fl.q[2])
  else $error("pci parity flag not cleared by one");

  dma_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (wr_ctrl && wdata[6] && !(dma_perr && parity_en)) |=> !fl.q[3])
  else $error("dma parity flag not cleared by one");

  fast_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (st_reg.fast_interrupt_enable_reg == 4'h0) |-> !fast_irq)
  else $error("fast interrupt without enable");

  init_store_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    wr_ctrl |=> (st_reg.init_done == $past(wdata[INIT_BIT])))
  else $error("init done bit not stored by write");
endmodule

// ==== testbench/serr_far_end.sv ====
`timescale 1ns/1ps
module serr_far_end (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // request from the bench to assert the error line for one cycle
  input wire logic fire,
  // drive of the block under test
  input wire logic serr_oe,
  input wire logic serr_out_n,
  // resolved line level
  output logic serr_in_n
);
  logic drive_reg;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      drive_reg <= 1'b0;
    else
      drive_reg <= fire;
  end
  // pulled-up line: low while either party pulls it down
  assign serr_in_n = !(drive_reg || (serr_oe && !serr_out_n));
endmodule

// ==== testbench/host_control_status_low_bits_tb_top.sv ====
`timescale 1ns/1ps
module host_control_status_low_bits_tb_top;
  import ctl_pkg::*;
  logic clk_sys, rstn, wr_en, rd_en, cfg_hit, iomem_hit, central_fn, cmd_serr_en;
  logic parity_en, fire, serr_in_n, serr_out_n, serr_oe, cfg_retry, cfg_normal;
  logic devsel_claim, normal_irq, fast_irq;
  logic rd_d = 1'b0;
  logic [2:0] perr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rnd;
  logic [DATA_W-1:0] exp_q[$];
  int err_count = 0, n_compared = 0, cyc = 0;

  proc_ctrl_status proc_ctrl_status_i (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cfg_hit(cfg_hit),
    .iomem_hit(iomem_hit), .cfg_retry(cfg_retry), .cfg_normal(cfg_normal),
    .devsel_claim(devsel_claim), .central_fn(central_fn), .cmd_serr_en(cmd_serr_en),
    .serr_in_n(serr_in_n), .serr_out_n(serr_out_n), .serr_oe(serr_oe),
    .parity_en(parity_en), .cpu_perr(perr[0]), .pci_perr(perr[1]), .dma_perr(perr[2]),
    .normal_irq(normal_irq), .fast_irq(fast_irq));
  serr_far_end serr_far_end_i (.clk_sys(clk_sys), .rstn(rstn), .fire(fire),
    .serr_oe(serr_oe), .serr_out_n(serr_out_n), .serr_in_n(serr_in_n));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (rd_d && exp_q.size() > 0)
      chk(rdata, exp_q.pop_front());
    rd_d <= rd_en;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      end_sim();
    end
  end

  initial
  begin
    {rstn, wr_en, rd_en, cfg_hit, iomem_hit, central_fn, cmd_serr_en} = '0;
    {parity_en, fire, perr, addr, wdata} = '0;
    rnd = $urandom(32'hFFA46625);
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(CTRL_OFS, 32'h0);
    rd(NIEN_OFS, 32'h0);
    rd(12'h200, 32'h0);
    @(posedge clk_sys);
    cfg_hit <= 1'b1;
    iomem_hit <= 1'b1;
    @(negedge clk_sys);
    chk(32'({cfg_retry, cfg_normal, devsel_claim}), 32'h4);
    rnd = $urandom() & 32'hFFFFFF84;
    // init is set only once the firmware setup beyond this block is done
    wr(CTRL_OFS, rnd | 32'h1);
    rd(CTRL_OFS, 32'h1);
    chk(32'({cfg_retry, cfg_normal, devsel_claim}), 32'h3);
    @(posedge clk_sys);
    cmd_serr_en <= 1'b1;
    wr(CTRL_OFS, 32'h3);
    for (int k = 0; k < 5 && serr_oe !== 1'b1; k++)
      @(negedge clk_sys);
    chk(32'({serr_oe, serr_out_n}), 32'h2);
    @(negedge clk_sys);
    chk(32'(serr_oe), 32'h0);
    rd(CTRL_OFS, 32'h3);
    // a request left standing must not pulse again
    chk(32'(serr_oe), 32'h0);
    wr(CTRL_OFS, 32'h1);
    wr(NIEN_OFS, 32'h78);
    wr(FIEN_OFS, 32'h10);
    rd(FIEN_OFS, 32'h10);
    @(posedge clk_sys);
    central_fn <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    rd(CTRL_OFS, 32'h9);
    chk(32'({normal_irq, fast_irq}), 32'h2);
    wr(CTRL_OFS, 32'h9);
    rd(CTRL_OFS, 32'h1);
    chk(32'(normal_irq), 32'h0);
    // each source first with checking off, then on
    for (int i = 0; i < 3; i++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        @(posedge clk_sys);
        parity_en <= p[0];
        perr[i] <= 1'b1;
        @(posedge clk_sys);
        perr <= 3'h0;
        rd(CTRL_OFS, 32'h1 | (p << (4 + i)));
      end
      chk(32'({normal_irq, fast_irq}), (i == 0) ? 32'h3 : 32'h2);
      wr(CTRL_OFS, 32'h1);
      rd(CTRL_OFS, 32'h1 | (32'h1 << (4 + i)));
      wr(CTRL_OFS, 32'h1 | (32'h1 << (4 + i)));
      rd(CTRL_OFS, 32'h1);
      chk(32'({normal_irq, fast_irq}), 32'h0);
    end
    // a request with the central function on must not pulse
    wr(CTRL_OFS, 32'h3);
    repeat (2) @(negedge clk_sys);
    chk(32'(serr_oe), 32'h0);
    // leave init, the request and a flag standing, then reset in mid-run
    @(posedge clk_sys);
    perr[0] <= 1'b1;
    @(posedge clk_sys);
    perr <= 3'h0;
    @(negedge clk_sys);
    chk(32'(normal_irq), 32'h1);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk(32'({cfg_retry, cfg_normal, devsel_claim, serr_oe, serr_out_n}), 32'h11);
    rd(CTRL_OFS, 32'h0);
    rd(NIEN_OFS, 32'h0);
    // a flag raised while both enables are clear stays silent
    @(posedge clk_sys);
    perr[2] <= 1'b1;
    @(posedge clk_sys);
    perr <= 3'h0;
    @(negedge clk_sys);
    chk(32'({normal_irq, fast_irq}), 32'h0);
    rd(CTRL_OFS, 32'h40);
    repeat (2) @(posedge clk_sys);
    end_sim();
  end
endmodule
